// File: design/pin_ctrl_map.svh
// Register offsets, field positions, reset values for the pin control block.
`ifndef PIN_CTRL_MAP_SVH
`define PIN_CTRL_MAP_SVH

// Register offsets on the plain register port.
`define ADDR_MODEM_CTRL_A   4'h0
`define ADDR_ENH_FEAT_A     4'h1
`define ADDR_MODEM_CTRL_B   4'h2
`define ADDR_ENH_FEAT_B     4'h3
`define ADDR_IO_PIN_FUNC    4'h4
`define ADDR_GPIO_DIR       4'h5
`define ADDR_GPIO_DATA      4'h6
`define ADDR_GPIO_STATE     4'h7
`define ADDR_PIN_STATUS     4'h8

// Field positions.
`define MCR_DTR_BIT         0
`define MCR_RTS_BIT         1
`define MCR_LOOP_BIT        4
`define EFR_AUTO_RTS_BIT    6
`define IO_GROUP_A_BIT      1
`define IO_GROUP_B_BIT      2

// Reset values.
`define RST_REG8            8'h00
`define RST_PINS            8'h00

`endif

// File: design/pin_ctrl_pkg.sv
// Types shared by the pin control modules.
package pin_ctrl_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [3:0] addr_t;
	// Function of one shared pin group.
	typedef enum logic [1:0] {
		ROLE_GPIO  = 2'b01,
		ROLE_MODEM = 2'b10
	} pin_role_e;
endpackage : pin_ctrl_pkg

// File: design/chan_if.sv
// Signals between the pin controller and one serial channel's pin logic.
interface chan_if;
	logic rts_bit;
	logic auto_rts;
	logic loopback;
	logic rx_room;
	logic tx_data;
	logic rx_pin;
	logic rts_n;
	logic serial_out;
	logic rx_core;
	logic flow_allow;
	modport ctrl (output rts_bit, auto_rts, loopback, rx_room, tx_data,
		rx_pin, input rts_n, serial_out, rx_core, flow_allow);
	modport chan (input rts_bit, auto_rts, loopback, rx_room, tx_data,
		rx_pin, output rts_n, serial_out, rx_core, flow_allow);
endinterface : chan_if

// File: design/chan_pin_ctrl.sv
// Request-to-send and loopback routing for one serial channel.
module chan_pin_ctrl (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic reset_n,
	// Channel signals.
	chan_if.chan      ch
);
	logic rts_n_q;
	logic serial_out_q;
	logic rx_core_q;
	logic rts_n_d;
	logic serial_out_d;
	logic rx_core_d;

	// Automatic flow asks only while the receiver has room; otherwise the
	// pin is the inverse of the software bit.
	assign rts_n_d = ch.auto_rts ? ~ch.rx_room : ~ch.rts_bit;
	// Receiver takes the transmit stream in loopback, the pin otherwise.
	assign rx_core_d = ch.loopback ? ch.tx_data : ch.rx_pin;
	// In loopback the line is held at idle mark so the far end sees no traffic.
	assign serial_out_d = ch.loopback ? 1'b1 : ch.tx_data;
	// Flow gating reaches the serial logic only under automatic mode.
	assign ch.flow_allow = ch.auto_rts ? ch.rx_room : 1'b1;

	// Pin outputs and rx_core are registered, flow_allow is not; one cycle of latency is cheap
	// against any bit time and keeps the pins glitch free.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rts_n_q      <= 1'b1;
			serial_out_q <= 1'b1;
			rx_core_q    <= 1'b1;
		end else begin
			rts_n_q      <= rts_n_d;
			serial_out_q <= serial_out_d;
			rx_core_q    <= rx_core_d;
		end
	end

	assign ch.rts_n      = rts_n_q;
	assign ch.serial_out = serial_out_q;
	assign ch.rx_core    = rx_core_q;
endmodule : chan_pin_ctrl

// File: design/uart_modem_pin_loopback_ctrl.sv
// Modem pin, loopback and shared pin function control for two channels.
//
// Chosen here: the register addresses and the plain strobed port.
`include "pin_ctrl_map.svh"

module uart_modem_pin_loopback_ctrl (
	// Clock and reset.
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	// Register port.
	input  wire pin_ctrl_pkg::addr_t  addr,
	input  wire pin_ctrl_pkg::reg8_t  wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output pin_ctrl_pkg::reg8_t       rdata,
	// Channel A serial path.
	input  wire logic                 tx_data_a,
	input  wire logic                 serial_in_a,
	output logic                      serial_out_a,
	output logic                      rx_data_a,
	input  wire logic                 rx_room_a,
	output logic                      rx_flow_allow_a,
	output logic                      request_to_send_a_n,
	// Channel B serial path.
	input  wire logic                 tx_data_b,
	input  wire logic                 serial_in_b,
	output logic                      serial_out_b,
	output logic                      rx_data_b,
	input  wire logic                 rx_room_b,
	output logic                      rx_flow_allow_b,
	output logic                      request_to_send_b_n,
	// Shared general purpose or modem pins.
	input  wire logic [7:0]           gpio_in,
	output logic [7:0]                gpio_out,
	output logic [7:0]                gpio_oe,
	// Modem inputs toward the channels, active low.
	output logic                      set_ready_a_n,
	output logic                      carrier_detect_a_n,
	output logic                      ring_a_n,
	output logic                      set_ready_b_n,
	output logic                      carrier_detect_b_n,
	output logic                      ring_b_n
);
	// Software registers.
	pin_ctrl_pkg::reg8_t modem_control_reg_a_q;
	pin_ctrl_pkg::reg8_t enhanced_features_reg_a_q;
	pin_ctrl_pkg::reg8_t modem_control_reg_b_q;
	pin_ctrl_pkg::reg8_t enhanced_features_reg_b_q;
	pin_ctrl_pkg::reg8_t io_pin_function_reg_q;
	pin_ctrl_pkg::reg8_t gpio_dir_q;
	pin_ctrl_pkg::reg8_t gpio_data_q;
	// Sampled pins, read data and registered outputs.
	logic [7:0]          gpio_pin_q;
	pin_ctrl_pkg::reg8_t rdata_q;
	pin_ctrl_pkg::reg8_t rdata_d;
	logic [7:0]          gpio_out_q;
	logic [7:0]          gpio_oe_q;
	logic [7:0]          gpio_out_d;
	logic [7:0]          gpio_oe_d;
	logic [5:0]          modem_in_q;
	logic [3:0]          modem_in_a;
	logic [3:0]          modem_in_b;
	// Decodes.
	logic                wr_mcr_a;
	logic                wr_efr_a;
	logic                wr_mcr_b;
	logic                wr_efr_b;
	logic                wr_io_func;
	logic                wr_dir;
	logic                wr_data;
	pin_ctrl_pkg::pin_role_e role_a;
	pin_ctrl_pkg::pin_role_e role_b;
	logic [7:0]          modem_out;
	logic [7:0]          modem_oe;
	pin_ctrl_pkg::reg8_t status_word;

	// Channel links.
	chan_if link_a ();
	chan_if link_b ();

	// Role of one group from its pin function bit.
	function automatic pin_ctrl_pkg::pin_role_e group_role(input logic sel);
		group_role = sel ? pin_ctrl_pkg::ROLE_MODEM : pin_ctrl_pkg::ROLE_GPIO;
	endfunction : group_role

	// Pick the modem or general purpose value of a four-line group.
	function automatic logic [3:0] group_pick(
		input pin_ctrl_pkg::pin_role_e role,
		input logic [3:0]              modem_val,
		input logic [3:0]              gpio_val
	);
		case (role)
			pin_ctrl_pkg::ROLE_MODEM: begin
				group_pick = modem_val;
			end
			pin_ctrl_pkg::ROLE_GPIO: begin
				group_pick = gpio_val;
			end
			default: begin
				group_pick = gpio_val;
			end
		endcase
	endfunction : group_pick

	// Write strobes, one per register.
	assign wr_mcr_a   = wr_stb && (addr == `ADDR_MODEM_CTRL_A);
	assign wr_efr_a   = wr_stb && (addr == `ADDR_ENH_FEAT_A);
	assign wr_mcr_b   = wr_stb && (addr == `ADDR_MODEM_CTRL_B);
	assign wr_efr_b   = wr_stb && (addr == `ADDR_ENH_FEAT_B);
	assign wr_io_func = wr_stb && (addr == `ADDR_IO_PIN_FUNC);
	assign wr_dir     = wr_stb && (addr == `ADDR_GPIO_DIR);
	assign wr_data    = wr_stb && (addr == `ADDR_GPIO_DATA);

	// Channel control registers; outside software control the request pins return high only through
	// this reset branch or, in automatic mode, when receive room is lost.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			modem_control_reg_a_q     <= `RST_REG8;
			enhanced_features_reg_a_q <= `RST_REG8;
			modem_control_reg_b_q     <= `RST_REG8;
			enhanced_features_reg_b_q <= `RST_REG8;
		end else begin
			if (wr_mcr_a) begin
				modem_control_reg_a_q <= wdata;
			end
			if (wr_efr_a) begin
				enhanced_features_reg_a_q <= wdata;
			end
			if (wr_mcr_b) begin
				modem_control_reg_b_q <= wdata;
			end
			if (wr_efr_b) begin
				enhanced_features_reg_b_q <= wdata;
			end
		end
	end

	// Shared pin configuration registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			io_pin_function_reg_q <= `RST_REG8;
			gpio_dir_q            <= `RST_REG8;
			gpio_data_q           <= `RST_REG8;
		end else begin
			if (wr_io_func) begin
				io_pin_function_reg_q <= wdata;
			end
			if (wr_dir) begin
				gpio_dir_q <= wdata;
			end
			if (wr_data) begin
				gpio_data_q <= wdata;
			end
		end
	end

	// Channel A link.
	assign link_a.rts_bit  = modem_control_reg_a_q[`MCR_RTS_BIT];
	assign link_a.auto_rts = enhanced_features_reg_a_q[`EFR_AUTO_RTS_BIT];
	assign link_a.loopback = modem_control_reg_a_q[`MCR_LOOP_BIT];
	assign link_a.rx_room  = rx_room_a;
	assign link_a.tx_data  = tx_data_a;
	assign link_a.rx_pin   = serial_in_a;

	// Channel B link.
	assign link_b.rts_bit  = modem_control_reg_b_q[`MCR_RTS_BIT];
	assign link_b.auto_rts = enhanced_features_reg_b_q[`EFR_AUTO_RTS_BIT];
	assign link_b.loopback = modem_control_reg_b_q[`MCR_LOOP_BIT];
	assign link_b.rx_room  = rx_room_b;
	assign link_b.tx_data  = tx_data_b;
	assign link_b.rx_pin   = serial_in_b;

	// Per-channel request and loopback logic.
	chan_pin_ctrl u_chan_a (
		.clk     (clk),
		.reset_n (reset_n),
		.ch      (link_a)
	);

	chan_pin_ctrl u_chan_b (
		.clk     (clk),
		.reset_n (reset_n),
		.ch      (link_b)
	);

	// Channel outputs back to the pins and the serial core.
	assign serial_out_a        = link_a.serial_out;
	assign rx_data_a           = link_a.rx_core;
	assign rx_flow_allow_a     = link_a.flow_allow;
	assign request_to_send_a_n = link_a.rts_n;
	assign serial_out_b        = link_b.serial_out;
	assign rx_data_b           = link_b.rx_core;
	assign rx_flow_allow_b     = link_b.flow_allow;
	assign request_to_send_b_n = link_b.rts_n;

	// Group roles: lower lines belong to channel B, upper lines to A.
	assign role_b = group_role(io_pin_function_reg_q[`IO_GROUP_B_BIT]);
	assign role_a = group_role(io_pin_function_reg_q[`IO_GROUP_A_BIT]);

	// Modem use of each group: line 1 of a group drives terminal ready
	// low when the control bit is set, the other three lines are inputs.
	assign modem_out = {2'b00, ~modem_control_reg_a_q[`MCR_DTR_BIT], 1'b0,
		2'b00, ~modem_control_reg_b_q[`MCR_DTR_BIT], 1'b0};
	assign modem_oe  = 8'h22;

	// Pin drive per group, chosen by role.
	assign gpio_out_d = {group_pick(role_a, modem_out[7:4], gpio_data_q[7:4]),
		group_pick(role_b, modem_out[3:0], gpio_data_q[3:0])};
	assign gpio_oe_d  = {group_pick(role_a, modem_oe[7:4], gpio_dir_q[7:4]),
		group_pick(role_b, modem_oe[3:0], gpio_dir_q[3:0])};

	// Modem view of each group; a group in general purpose use reads idle.
	assign modem_in_a = group_pick(role_a, gpio_in[7:4], 4'hF);
	assign modem_in_b = group_pick(role_b, gpio_in[3:0], 4'hF);

	// Registered pin drive; modem inputs read idle high while a group is
	// in general purpose use so the channel sees no false modem events.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gpio_out_q <= `RST_PINS;
			gpio_oe_q  <= `RST_PINS;
			gpio_pin_q <= `RST_PINS;
			modem_in_q <= 6'h3F;
		end else begin
			gpio_out_q <= gpio_out_d;
			gpio_oe_q  <= gpio_oe_d;
			gpio_pin_q <= gpio_in;
			modem_in_q <= {modem_in_a[3], modem_in_a[2], modem_in_a[0],
				modem_in_b[3], modem_in_b[2], modem_in_b[0]};
		end
	end

	assign gpio_out           = gpio_out_q;
	assign gpio_oe            = gpio_oe_q;
	assign ring_a_n           = modem_in_q[5];
	assign carrier_detect_a_n = modem_in_q[4];
	assign set_ready_a_n      = modem_in_q[3];
	assign ring_b_n           = modem_in_q[2];
	assign carrier_detect_b_n = modem_in_q[1];
	assign set_ready_b_n      = modem_in_q[0];

	// Live pin status visible to software.
	assign status_word = {4'h0, link_b.loopback, link_a.loopback,
		request_to_send_b_n, request_to_send_a_n};

	// Read mux; unmapped offsets return zero.
	always_comb begin
		case (addr)
			`ADDR_MODEM_CTRL_A: begin
				rdata_d = modem_control_reg_a_q;
			end
			`ADDR_ENH_FEAT_A: begin
				rdata_d = enhanced_features_reg_a_q;
			end
			`ADDR_MODEM_CTRL_B: begin
				rdata_d = modem_control_reg_b_q;
			end
			`ADDR_ENH_FEAT_B: begin
				rdata_d = enhanced_features_reg_b_q;
			end
			`ADDR_IO_PIN_FUNC: begin
				rdata_d = io_pin_function_reg_q;
			end
			`ADDR_GPIO_DIR: begin
				rdata_d = gpio_dir_q;
			end
			`ADDR_GPIO_DATA: begin
				rdata_d = gpio_data_q;
			end
			`ADDR_GPIO_STATE: begin
				rdata_d = gpio_pin_q;
			end
			`ADDR_PIN_STATUS: begin
				rdata_d = status_word;
			end
			default: begin
				rdata_d = `RST_REG8;
			end
		endcase
	end

	// Read data stands for the single cycle after the strobe.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= `RST_REG8;
		end else if (rd_stb) begin
			rdata_q <= rdata_d;
		end else begin
			rdata_q <= `RST_REG8;
		end
	end

	assign rdata = rdata_q;
endmodule : uart_modem_pin_loopback_ctrl

// File: tb/pin_ctrl_chk.sv
// Port checker for the modem pin and loopback control block.
module pin_ctrl_chk (
	// Clock and reset.
	input wire logic		clk,
	input wire logic		reset_n,
	// Register port.
	input wire pin_ctrl_pkg::addr_t	addr,
	input wire pin_ctrl_pkg::reg8_t	wdata,
	input wire logic		wr_stb,
	input wire pin_ctrl_pkg::reg8_t	rdata,
	// Serial paths.
	input wire logic		tx_data_a,
	input wire logic		serial_in_a,
	input wire logic		serial_out_a,
	input wire logic		rx_data_a,
	input wire logic		rx_room_a,
	input wire logic		rx_flow_allow_a,
	input wire logic		request_to_send_a_n,
	input wire logic		rx_room_b,
	input wire logic		request_to_send_b_n,
	// Shared pins and modem inputs.
	input wire logic [7:0]		gpio_in,
	input wire logic		set_ready_a_n,
	input wire logic		carrier_detect_a_n,
	input wire logic		set_ready_b_n,
	input wire logic		ring_b_n
);
	timeunit 1ns;
	timeprecision 1ns;
	pin_ctrl_pkg::reg8_t mcr_a_q, efr_a_q, mcr_b_q, efr_b_q, io_q;
	logic run_q;

	// Expected pin values, each one cycle ahead of its flop.
	wire exp_rts_a = efr_a_q[6] ? !rx_room_a : !mcr_a_q[1];
	wire exp_rts_b = efr_b_q[6] ? !rx_room_b : !mcr_b_q[1];
	wire exp_rx_a = mcr_a_q[4] ? tx_data_a : serial_in_a;
	wire exp_dsr_a = !io_q[1] | gpio_in[4];
	wire exp_cd_a = !io_q[1] | gpio_in[6];
	wire exp_dsr_b = !io_q[2] | gpio_in[0];
	wire exp_ri_b = !io_q[2] | gpio_in[3];

	// Mirror of the written registers, so pins are judged from the port.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mcr_a_q <= 8'h00;
			efr_a_q <= 8'h00;
			mcr_b_q <= 8'h00;
			efr_b_q <= 8'h00;
			io_q <= 8'h00;
		end else if (wr_stb) begin
			case (addr)
				4'h0: mcr_a_q <= wdata;
				4'h1: efr_a_q <= wdata;
				4'h2: mcr_b_q <= wdata;
				4'h3: efr_b_q <= wdata;
				4'h4: io_q <= wdata;
				default: ;
			endcase
		end
	end

	// High from the first edge after a release, so that no comparison
	// looks back into a cycle in which the flops were held in reset.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_q <= 1'b0;
		end else begin
			run_q <= 1'b1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_rts_a_follow: assert property (run_q |->
		request_to_send_a_n == $past(exp_rts_a))
		else $error("request a does not follow its source");
	a_rts_b_follow: assert property (run_q |->
		request_to_send_b_n == $past(exp_rts_b))
		else $error("request b does not follow its source");
	a_flow_gate: assert property (
		rx_flow_allow_a == (!efr_a_q[6] || rx_room_a))
		else $error("flow allow a wrong for auto mode");
	a_loop_echo: assert property (run_q |->
		rx_data_a == $past(exp_rx_a))
		else $error("receiver input a has wrong source");
	a_loop_quiet: assert property (mcr_a_q[4] [*2] |-> serial_out_a)
		else $error("transmit pin a driven in loopback");
	a_lower_group: assert property (run_q |->
		set_ready_b_n == $past(exp_dsr_b) && ring_b_n == $past(exp_ri_b))
		else $error("lower pin group role wrong");
	a_upper_group: assert property (run_q |->
		set_ready_a_n == $past(exp_dsr_a) && carrier_detect_a_n ==
		$past(exp_cd_a)) else $error("upper pin group role wrong");
	a_reset_idle: assert property (disable iff (1'b0) !reset_n |->
		request_to_send_a_n && request_to_send_b_n && rdata == 8'h00)
		else $error("outputs not idle in reset");
endmodule : pin_ctrl_chk

bind uart_modem_pin_loopback_ctrl pin_ctrl_chk pin_ctrl_chk_i (.clk,
	.reset_n, .addr, .wdata, .wr_stb, .rdata, .tx_data_a, .serial_in_a,
	.serial_out_a, .rx_data_a, .rx_room_a, .rx_flow_allow_a,
	.request_to_send_a_n, .rx_room_b, .request_to_send_b_n, .gpio_in,
	.set_ready_a_n, .carrier_detect_a_n, .set_ready_b_n, .ring_b_n);

// File: tb/line_partner.sv
// Far-side line model: a remote sender that never rests on the wire.
module line_partner (
	// Clock.
	input wire logic	clk,
	// Receive lines toward the block.
	output logic		serial_in_a,
	output logic		serial_in_b
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] pat_q = 2'h1;

	// Line a changes every cycle and line b every second cycle, so a receive pin that leaks through shows.
	always_ff @(posedge clk) begin
		pat_q <= pat_q + 2'h1;
	end
	assign serial_in_a = pat_q[0];
	assign serial_in_b = pat_q[1];
endmodule : line_partner

// File: tb/uart_modem_pin_loopback_ctrl_test.sv
// Self-checking bench for the modem pin and loopback control block.
`define CMP(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
	$display("unexpected %s exp %h got %h", nm, ex, got); fails++; end end

module uart_modem_pin_loopback_ctrl_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, reset_n = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
	pin_ctrl_pkg::addr_t addr = 4'h0;
	pin_ctrl_pkg::reg8_t wdata = 8'h00, rdata;
	logic tx_data_a = 1'b1, tx_data_b = 1'b1;
	logic rx_room_a = 1'b0, rx_room_b = 1'b0;
	logic [7:0] gpio_in = 8'h00, gpio_out, gpio_oe;
	logic serial_in_a, serial_in_b, serial_out_a, serial_out_b;
	logic rx_data_a, rx_data_b, rx_flow_allow_a, rx_flow_allow_b;
	logic request_to_send_a_n, request_to_send_b_n, set_ready_a_n;
	logic carrier_detect_a_n, ring_a_n, set_ready_b_n;
	logic carrier_detect_b_n, ring_b_n;
	int fails = 0, checks_done = 0;

	uart_modem_pin_loopback_ctrl uart_modem_pin_loopback_ctrl_i (.clk,
		.reset_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .tx_data_a,
		.serial_in_a, .serial_out_a, .rx_data_a, .rx_room_a,
		.rx_flow_allow_a, .request_to_send_a_n, .tx_data_b, .serial_in_b,
		.serial_out_b, .rx_data_b, .rx_room_b, .rx_flow_allow_b,
		.request_to_send_b_n, .gpio_in, .gpio_out, .gpio_oe,
		.set_ready_a_n, .carrier_detect_a_n, .ring_a_n, .set_ready_b_n,
		.carrier_detect_b_n, .ring_b_n);
	line_partner line_partner_i (.clk, .serial_in_a, .serial_in_b);

	// Free-running clock, 100 ns period.
	always #50 clk = ~clk;

	task automatic close_out;
		if (fails == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// Waits edges, then 1 ns so that registered outputs have settled.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick

	task automatic wr(input pin_ctrl_pkg::addr_t a,
		input pin_ctrl_pkg::reg8_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask : wr

	task automatic rd_chk(input pin_ctrl_pkg::addr_t a,
		input pin_ctrl_pkg::reg8_t ex);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1;
		`CMP("rdata", ex, rdata)
	endtask : rd_chk

	task automatic t_reset;
		`CMP("rts a", 1'b1, request_to_send_a_n)
		`CMP("rts b", 1'b1, request_to_send_b_n)
		`CMP("allow b", 1'b1, rx_flow_allow_b)
		rd_chk(4'h8, 8'h03);
		rd_chk(4'hF, 8'h00);
	endtask : t_reset

	task automatic t_rts;
		wr(4'h0, 8'h02);
		wr(4'h2, 8'h02);
		tick(2);
		`CMP("rts a", 1'b0, request_to_send_a_n)
		`CMP("rts b", 1'b0, request_to_send_b_n)
		rd_chk(4'h8, 8'h00);
		wr(4'h0, 8'h00);
		tick(2);
		`CMP("rts a", 1'b1, request_to_send_a_n)
		`CMP("rts b", 1'b0, request_to_send_b_n)
		wr(4'h2, 8'h00);
	endtask : t_rts

	// Auto mode: the request pin follows receive room, the bit is ignored.
	task automatic t_auto;
		wr(4'h1, 8'h40);
		wr(4'h0, 8'h02);
		tick(2);
		`CMP("rts a", 1'b1, request_to_send_a_n)
		`CMP("allow a", 1'b0, rx_flow_allow_a)
		@(posedge clk);
		rx_room_a <= 1'b1;
		tick(2);
		`CMP("rts a", 1'b0, request_to_send_a_n)
		`CMP("allow a", 1'b1, rx_flow_allow_a)
		wr(4'h1, 8'h00);
		rx_room_a <= 1'b0;
		tick(2);
		`CMP("allow a", 1'b1, rx_flow_allow_a)
		`CMP("rts a", 1'b0, request_to_send_a_n)
		wr(4'h0, 8'h00);
	endtask : t_auto

	task automatic t_loop;
		wr(4'h0, 8'h10);
		wr(4'h2, 8'h10);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			tx_data_a <= i[0];
			tx_data_b <= !i[0];
			tick(1);
			`CMP("rx a", i[0], rx_data_a)
			`CMP("rx b", !i[0], rx_data_b)
			`CMP("tx a", 1'b1, serial_out_a)
			`CMP("tx b", 1'b1, serial_out_b)
		end
		rd_chk(4'h8, 8'h0F);
		wr(4'h0, 8'h00);
		tx_data_a <= 1'b0;
		tick(2);
		`CMP("tx a", 1'b0, serial_out_a)
		wr(4'h2, 8'h00);
	endtask : t_loop

	task automatic t_pins;
		gpio_in <= 8'h88;
		wr(4'h5, 8'hF0);
		wr(4'h6, 8'hA5);
		wr(4'h4, 8'h04);
		tick(2);
		`CMP("dsr b", 1'b0, set_ready_b_n)
		`CMP("ri b", 1'b1, ring_b_n)
		`CMP("cd b", 1'b0, carrier_detect_b_n)
		`CMP("dsr a", 1'b1, set_ready_a_n)
		`CMP("pin oe", 8'hF2, gpio_oe)
		`CMP("pin out", 8'hA2, gpio_out)
		rd_chk(4'h7, 8'h88);
		wr(4'h4, 8'h02);
		tick(2);
		`CMP("dsr a", 1'b0, set_ready_a_n)
		`CMP("dsr b", 1'b1, set_ready_b_n)
		`CMP("pin oe", 8'h20, gpio_oe)
		`CMP("pin out", 8'h25, gpio_out)
		wr(4'h0, 8'h01);
		tick(2);
		`CMP("pin out", 8'h05, gpio_out)
		wr(4'h0, 8'h00);
		@(posedge clk);
		gpio_in <= 8'h77;
		tick(2);
		`CMP("cd a", 1'b1, carrier_detect_a_n)
		`CMP("ri a", 1'b0, ring_a_n)
		wr(4'h4, 8'h00);
	endtask : t_pins

	// A reset in mid-run must idle the request pin at once and clear it.
	task automatic t_rereset;
		wr(4'h0, 8'h02);
		tick(2);
		@(posedge clk);
		reset_n <= 1'b0;
		#1;
		`CMP("rts a", 1'b1, request_to_send_a_n)
		@(posedge clk);
		reset_n <= 1'b1;
		tick(2);
		`CMP("rts a", 1'b1, request_to_send_a_n)
	endtask : t_rereset

	// Reset falls at time zero so the asynchronous clear acts before the
	// first edge and no output is unknown when the checker first looks.
	initial begin
		reset_n <= 1'b0;
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		tick(1);
		t_reset;
		t_rts;
		t_auto;
		t_loop;
		t_pins;
		t_rereset;
		close_out;
	end

	// Watchdog: a run that hangs is cut off and counted as a mismatch.
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		close_out;
	end
endmodule : uart_modem_pin_loopback_ctrl_test
